// ==== pkg/actc_pkg.sv ====
// constants and register layout for the timer control block
// assumes a single 200 MHz clock and an apb register port
//
// How it works
// RULE1: enable bit 15 runs or stops timer
// RULE2: idle_stop bit 13 halts counting in idle
// RULE3: block set: discard count writes while pending
// RULE4: block clear: accept back-to-back count writes
// RULE5: pending flag high until async write lands
// RULE6: pending flag reads zero in sync mode
// RULE7: gate bit ignored with external clock
// RULE8: internal clock: gate input qualifies counting
// RULE9: prescale codes divide by 1, 8, 64, 256
// RULE10: unimplemented bits read zero, ignore writes
// RULE11: software avoids access right after disabling
// RULE12: bit 1 selects external or bus clock
// RULE13: bit 2 synchronises external clock when set; the code always synchronises it, bit 2 only selects sync count writes
package actc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int BIT_ENABLE = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_WRITE_BLOCK = 12;
  localparam int BIT_WRITE_PENDING = 11;
  localparam int BIT_GATE = 7;
  localparam int BIT_PRESCALE_HI = 5;
  localparam int BIT_PRESCALE_LO = 4;
  localparam int BIT_EXT_SYNC = 2;
  localparam int BIT_CLOCK_SOURCE = 1;

  // writable bits of the control word; everything else is read-as-zero except the pending flag, bit 11
  localparam logic [31:0] CONTROL_WRITE_MASK = 32'h0000_b0b6;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;

  // ---------------------------------------------------------------
  // prescale codes and divide ratios
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    actc_div1_type_e = 2'b00,
    actc_div8_type_e = 2'b01,
    actc_div64_type_e = 2'b10,
    actc_div256_type_e = 2'b11
  } actc_prescale_type;

  localparam int DIV_BY_1 = 1;
  localparam int DIV_BY_8 = 8;
  localparam int DIV_BY_64 = 64;
  localparam int DIV_BY_256 = 256;

  // cycles an asynchronous count write takes to land in the counter
  localparam int ASYNC_WRITE_CYCLES = 3;

endpackage

// ==== sim/actc_timer_sva.sv ====
// checker for the timer control block
// assumes it is bound to actc_timer and sees only its ports
`timescale 1ns/1ps
module actc_timer_sva (
  input wire logic clock, // clock
  input wire logic rst_n, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pslverr, // apb error
  input wire logic idle_mode, // idle level
  input wire logic [15:0] count_value // count
);
  logic [31:0] ctrl;
  logic [2:0] quiet;
  logic [3:0] ihist;
  wire acc = psel && penable;
  wire wr_cnt = acc && pwrite && paddr == 8'h04;
  wire rd_ctl = psel && !penable && !pwrite && paddr == 8'h00;
  wire async_md = ctrl[1] && !ctrl[2];
  // ----------------------------------------------------------------
  // mirror of the control word; quiet counts cycles since a write
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= 32'h0;
      quiet <= 3'h0;
      ihist <= 4'h0;
    end else begin
      ctrl <= (acc && pwrite && paddr == 8'h00) ? pwdata : ctrl;
      quiet <= (acc && pwrite) ? 3'h0 : ((quiet == 3'h7) ? quiet : quiet + 3'h1);
      ihist <= {ihist[2:0], idle_mode};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_unmapped_error: assert property (acc && !(paddr inside {8'h00, 8'h04, 8'h08}) |-> pslverr)
    else $error("unmapped access without error");
  chk_ctrl_zeros: assert property (rd_ctl |=> (prdata & ~32'h0000_b8b6) == 32'h0)
    else $error("unimplemented control bits read nonzero");
  chk_sync_pend: assert property (rd_ctl && !async_md |=> !prdata[11])
    else $error("pending flag set in sync mode");
  chk_stop_off: assert property (!ctrl[15] && quiet == 3'h7 |=> $stable(count_value))
    else $error("count moved while disabled");
  chk_idle_halt: assert property (ctrl[13] && idle_mode && ihist == 4'hf && quiet == 3'h7 |=>
    $stable(count_value))
    else $error("count moved in idle with idle stop");
  chk_count_step: assert property (ctrl[15] && ctrl[5:4] == 2'b00 && ctrl[13:12] != 2'b10 &&
    !ctrl[1] && !ctrl[7] && !ctrl[13] && !wr_cnt && quiet == 3'h7 |=>
    count_value == $past(count_value) + 16'h1 || count_value == 16'h0)
    else $error("count did not step by one");
  chk_sync_load: assert property (wr_cnt && !async_md && !ctrl[15] |=>
    count_value == $past(pwdata[15:0]))
    else $error("sync count write did not land");
  chk_async_land: assert property (wr_cnt && async_md && !ctrl[12] && !ctrl[15] ##1
    (!wr_cnt) [*3] |=> count_value == $past(pwdata[15:0], 4))
    else $error("async count write did not land");
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the timer control block
// assumes actc_timer and its checker are compiled first
`timescale 1ns/1ps
module testbench;
  logic clock, rst_n, psel, penable, pwrite, idle_mode, ext_clock, gate_in, ext_run;
  logic pready, pslverr, period_match, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] count_value;
  logic [1:0] ed;
  int error_cnt = 0;
  int comparisons = 0;
  int match_cnt = 0;
  actc_timer uut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .idle_mode(idle_mode), .ext_clock(ext_clock), .gate_in(gate_in),
    .count_value(count_value), .period_match(period_match));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // external clock of four system cycles, low while not in use
  always @(posedge clock) begin
    ed <= ed + 2'h1;
    ext_clock <= ext_run & ed[1];
  end
  // counts period rollover pulses for the period scenario
  always @(posedge clock) begin
    if (period_match === 1'b1) match_cnt <= match_cnt + 1;
  end
  task stop_test();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  // hold keeps psel up so the next setup follows at once
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic hold);
    int i;
    if (psel !== 1'b1) psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
    if (!hold) psel <= 1'b0;
    if (i == 16) begin
      error_cnt++;
      stop_test();
    end
  endtask
  // clear count, run with ctl for n+2 cycles, stop, read count into rd
  task run(input logic [31:0] ctl, input int n);
    @(posedge clock); xfer(1'b1, 8'h04, 32'h0, 1'b0);
    @(posedge clock); xfer(1'b1, 8'h00, ctl, 1'b0);
    repeat (n) @(posedge clock);
    xfer(1'b1, 8'h00, 32'h0, 1'b0);
    @(posedge clock); xfer(1'b0, 8'h04, 32'h0, 1'b0);
  endtask
  task t_regs();
    @(posedge clock); xfer(1'b0, 8'h00, 32'h0, 1'b0);
    chk(rd, 32'h0, 32'h0);
    @(posedge clock); xfer(1'b1, 8'h00, 32'hffff_ffff, 1'b0);
    @(posedge clock); xfer(1'b0, 8'h00, 32'h0, 1'b0);
    chk(rd, 32'h0000_b0b6, 32'h0000_b0b6);
    @(posedge clock); xfer(1'b0, 8'h0c, 32'h0, 1'b0);
    chk({rd[30:0], err}, 32'h1, 32'h1);
  endtask
  task t_div();
    int r[4] = '{actc_pkg::DIV_BY_1, actc_pkg::DIV_BY_8, actc_pkg::DIV_BY_64,
      actc_pkg::DIV_BY_256};
    for (int k = 0; k < 4; k++) begin
      run(32'h0000_8000 | (k << 4), r[k] * 8 - 2);
      chk(rd, 32'h6, 32'h9);
    end
  endtask
  task t_mode();
    idle_mode <= 1'b1;
    run(32'h0000_a000, 20); chk(rd, 32'h0, 32'h0);
    run(32'h0000_8000, 20); chk(rd, 32'd17, 32'd22);
    idle_mode <= 1'b0;
    gate_in <= 1'b0;
    run(32'h0000_8080, 20); chk(rd, 32'h0, 32'h0);
    gate_in <= 1'b1;
    run(32'h0000_8080, 20); chk(rd, 32'd17, 32'd22);
    gate_in <= 1'b0;
    ext_run <= 1'b1;
    run(32'h0000_8086, 20); chk(rd, 32'h3, 32'h6);
    run(32'h0000_8082, 20); chk(rd, 32'h3, 32'h6);
    ext_run <= 1'b0;
  endtask
  // period 3 with divide by one: 40 ticks give ten rollovers, count ends at zero
  task t_period();
    int m;
    @(posedge clock); xfer(1'b0, 8'h08, 32'h0, 1'b0);
    chk(rd, 32'h0000_ffff, 32'h0000_ffff);
    @(posedge clock); xfer(1'b1, 8'h08, 32'h3, 1'b0);
    m = match_cnt;
    run(32'h0000_8000, 38);
    chk(rd, 32'h0, 32'h0);
    chk(match_cnt - m, 32'd10, 32'd10);
    @(posedge clock); xfer(1'b1, 8'h08, 32'hffff, 1'b0);
  endtask
  task t_async(input logic [31:0] ctl, input logic [31:0] exp);
    @(posedge clock); xfer(1'b1, 8'h00, ctl, 1'b0);
    @(posedge clock); xfer(1'b1, 8'h04, 32'h3333, 1'b1);
    // second write differs from the first, so a dropped write is visible
    xfer(1'b1, 8'h04, 32'h2222, 1'b1);
    xfer(1'b0, 8'h00, 32'h0, 1'b0);
    chk({31'h0, rd[11]}, 32'h1, 32'h1);
    repeat (6) @(posedge clock);
    xfer(1'b0, 8'h00, 32'h0, 1'b0);
    chk({31'h0, rd[11]}, 32'h0, 32'h0);
    @(posedge clock); xfer(1'b0, 8'h04, 32'h0, 1'b0);
    chk(rd, exp, exp);
  endtask
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
    pwdata = 32'h0; idle_mode = 1'b0; gate_in = 1'b0; ext_run = 1'b0; ed = 2'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_div();
    t_mode();
    t_period();
    t_async(32'h0000_0002, 32'h2222);
    t_async(32'h0000_1002, 32'h3333);
    stop_test();
  end
endmodule
bind actc_timer actc_timer_sva u_sva (.clock(clock), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .idle_mode(idle_mode), .count_value(count_value));

// ==== verilog/actc_edge_sync.sv ====
// two-flop synchroniser with rising-edge detect on the second stage
// assumes the input is an external level of unknown phase
`timescale 1ns/1ps
module actc_edge_sync (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic level_in, // raw level
  output logic level_out, // synchronised level
  output logic rise // one-cycle pulse on rising edge
);
  logic stage_one;
  logic stage_two;
  logic stage_three;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= 1'b0;
      stage_two <= 1'b0;
      stage_three <= 1'b0;
    end else begin
      stage_one <= level_in;
      stage_two <= stage_one;
      stage_three <= stage_two;
    end
  end

  assign level_out = stage_two;
  assign rise = stage_two & ~stage_three;
endmodule

// ==== verilog/actc_prescaler.sv ====
// prescaler: turns source ticks into count enables, ratio 1/8/64/256
// assumes tick_in is a one-cycle pulse in the clock domain
`timescale 1ns/1ps
module actc_prescaler (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic clear, // restart division
  input wire logic [1:0] select, // prescale code
  input wire logic tick_in, // source tick
  output logic tick_out // divided tick, one cycle
);
  logic [7:0] count;
  logic [7:0] limit;
  logic wrap;

  // see RULE9
  assign limit = (select == actc_pkg::actc_div256_type_e) ? 8'(actc_pkg::DIV_BY_256 - 1) :
                 (select == actc_pkg::actc_div64_type_e) ? 8'(actc_pkg::DIV_BY_64 - 1) :
                 (select == actc_pkg::actc_div8_type_e) ? 8'(actc_pkg::DIV_BY_8 - 1) :
                 8'(actc_pkg::DIV_BY_1 - 1);
  assign wrap = tick_in && (count >= limit);
  assign tick_out = wrap;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
    end else if (clear || wrap) begin
      count <= 8'h00;
    end else if (tick_in) begin
      count <= count + 8'h01;
    end
  end
endmodule

// ==== verilog/actc_timer.sv ====
// timer control block: apb control/count/period registers and count engine
// assumes apb master per the amba spec, external clock and gate are raw levels
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
module actc_timer (
  input wire logic clock, // 200 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic idle_mode, // device in idle
  input wire logic ext_clock, // external timer clock pin
  input wire logic gate_in, // gate input, active high
  output logic [15:0] count_value, // current count
  output logic period_match // one-cycle pulse on period rollover
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] timer_one_control;
  logic [15:0] count;
  logic [15:0] period;
  logic async_write_pending;
  logic [15:0] pending_data;
  logic [1:0] land_count;
  logic match_pulse;
  logic [31:0] read_data;

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  wire enable = timer_one_control[actc_pkg::BIT_ENABLE];
  wire idle_stop = timer_one_control[actc_pkg::BIT_IDLE_STOP];
  wire async_write_block = timer_one_control[actc_pkg::BIT_WRITE_BLOCK];
  wire gated_accumulate_enable = timer_one_control[actc_pkg::BIT_GATE];
  wire [1:0] prescale_select =
    timer_one_control[actc_pkg::BIT_PRESCALE_HI:actc_pkg::BIT_PRESCALE_LO];
  wire ext_clock_sync = timer_one_control[actc_pkg::BIT_EXT_SYNC];
  wire clock_source_select = timer_one_control[actc_pkg::BIT_CLOCK_SOURCE];

  // async mode only exists with the external clock and sync cleared
  wire async_mode = clock_source_select & ~ext_clock_sync; // see RULE13

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire hit_control = (paddr == actc_pkg::ADDR_CONTROL);
  wire hit_count = (paddr == actc_pkg::ADDR_COUNT);
  wire hit_period = (paddr == actc_pkg::ADDR_PERIOD);
  wire mapped = hit_control | hit_count | hit_period;
  wire access = psel & penable;
  wire wr = access & pwrite & mapped;
  wire wr_control = wr & hit_control;
  wire wr_count = wr & hit_count;
  wire wr_period = wr & hit_period;

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // see RULE3 see RULE4
  wire count_write_taken = wr_count & ~(async_write_block & async_write_pending);
  wire start_async = count_write_taken & async_mode;
  wire sync_load = count_write_taken & ~async_mode;

  // ---------------------------------------------------------------
  // clock source and tick generation
  // ---------------------------------------------------------------
  logic ext_rise;

  actc_edge_sync ext_sync_u (
    .clock(clock),
    .rst_n(rst_n),
    .level_in(ext_clock),
    .level_out(),
    .rise(ext_rise)
  );

  // the external edge is always resynchronised here; the sync bit only changes
  // how count writes land, since the block has one clock domain
  wire source_tick = clock_source_select ? ext_rise : 1'b1; // see RULE12

  // see RULE7 see RULE8
  wire gate_ok = clock_source_select | ~gated_accumulate_enable | gate_in;
  // see RULE1 see RULE2
  wire run = enable & ~(idle_stop & idle_mode);

  logic tick;
  actc_prescaler prescale_u (
    .clock(clock),
    .rst_n(rst_n),
    .clear(~enable),
    .select(prescale_select),
    .tick_in(source_tick & run & gate_ok), // see RULE9
    .tick_out(tick)
  );

  wire at_period = (count == period);
  wire land_now = async_write_pending && (land_count == 2'(actc_pkg::ASYNC_WRITE_CYCLES - 1));

  // ---------------------------------------------------------------
  // control and period registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_one_control <= actc_pkg::CONTROL_RESET;
    end else if (wr_control) begin
      timer_one_control <= pwdata & actc_pkg::CONTROL_WRITE_MASK; // see RULE10
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      period <= actc_pkg::PERIOD_RESET;
    end else if (wr_period) begin
      period <= pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // asynchronous write tracking
  // ---------------------------------------------------------------
  // a new accepted write restarts the landing delay so the last value wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      async_write_pending <= 1'b0;
      pending_data <= actc_pkg::COUNT_RESET;
      land_count <= 2'b00;
    end else if (start_async) begin
      async_write_pending <= 1'b1; // see RULE5
      pending_data <= pwdata[15:0];
      land_count <= 2'b00;
    end else if (land_now) begin
      async_write_pending <= 1'b0; // see RULE5
    end else if (async_write_pending) begin
      land_count <= land_count + 2'b01;
    end
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= actc_pkg::COUNT_RESET;
      match_pulse <= 1'b0;
    end else begin
      match_pulse <= 1'b0;
      if (sync_load) begin
        count <= pwdata[15:0];
      end else if (land_now) begin
        count <= pending_data;
      end else if (tick) begin
        if (at_period) begin
          count <= 16'h0000;
          match_pulse <= 1'b1;
        end else begin
          count <= count + 16'h0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // see RULE6: the pending flag is masked outside asynchronous mode
  wire pending_view = async_write_pending & async_mode;
  wire [31:0] control_view = timer_one_control |
    (32'(pending_view) << actc_pkg::BIT_WRITE_PENDING);
  assign read_data = hit_control ? control_view :
                     hit_count ? {16'h0000, count} :
                     hit_period ? {16'h0000, period} : 32'h0000_0000;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= read_data;
    end
  end

  assign count_value = count;
  assign period_match = match_pulse;
  // software keeps clear of the registers right after disabling, see RULE11
endmodule
